// file: pkg/dif_pkg.sv
// How it works
// - Emergency input seen while operation enabled drops drive to switched-on standby.
// - Run and stop functions act only in analog mode, without fieldbus control.
// - Every entry of both input objects is read-only; writes are refused.
// - Function field codes: 0 none, 1 run, 2 stop, 3 emergency, 4 reset, 5/6 limits.
// - State field reads the pin level, 0 for low and 1 for high, whatever the edge select.
// - Edge field reads 0 for positive edge trigger, 1 for negative edge.
// - Unimplemented sub-index is answered with abort code 0x06090011.
// - Reset input is filtered for 100 ms before it fires a hardware reset.
// - While a limit input reads 1 the drive is held in its stop state.
package dif_pkg;

  // Object dictionary indexes of the two input objects
  localparam logic [15:0] DIF_IDX_INPUT_ONE = 16'h3021;
  localparam logic [15:0] DIF_IDX_INPUT_TWO = 16'h3022;

  // Sub-index layout inside each object
  localparam logic [7:0] DIF_SUB_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] DIF_SUB_FUNC_SELECT = 8'h01;
  localparam logic [7:0] DIF_SUB_LEVEL_STATE = 8'h02;
  localparam logic [7:0] DIF_SUB_EDGE_SELECT = 8'h03;

  // Reset value of the entry count entry
  localparam logic [15:0] DIF_ENTRY_COUNT_RST = 16'h0005;

  // Abort answer for a sub-index that does not exist
  localparam logic [31:0] DIF_ABORT_NO_SUBINDEX = 32'h06090011;

  // Function assignment codes
  typedef enum logic [15:0] {
    DIF_FUNC_NONE = 16'h0000,
    DIF_FUNC_RUN = 16'h0001,
    DIF_FUNC_STOP = 16'h0002,
    DIF_FUNC_EMERGENCY = 16'h0003,
    DIF_FUNC_RESET = 16'h0004,
    DIF_FUNC_CLOCKWISE_LIMIT = 16'h0005,
    DIF_FUNC_COUNTER_CLOCKWISE_LIMIT = 16'h0006
  } dif_func_t;

  // Edge select codes
  localparam logic [15:0] DIF_EDGE_POSITIVE = 16'h0000;
  localparam logic [15:0] DIF_EDGE_NEGATIVE = 16'h0001;

  // Input state codes
  localparam logic [15:0] DIF_STATE_LOW = 16'h0000;
  localparam logic [15:0] DIF_STATE_HIGH = 16'h0001;

  // Timing: clock rate and reset filter time
  localparam int DIF_CLK_HZ = 40000000;
  localparam int DIF_RESET_FILTER_MS = 100;
  localparam int DIF_RESET_FILTER_CYCLES =
    (DIF_CLK_HZ / 1000) * DIF_RESET_FILTER_MS;

endpackage : dif_pkg

// file: design/dif_inputs.sv
`timescale 1ns/10ps
module dif_inputs
  import dif_pkg::*;
#(
  parameter logic [15:0] IN1_FUNC = DIF_FUNC_RUN,
  parameter logic [15:0] IN1_EDGE = DIF_EDGE_POSITIVE,
  parameter logic [15:0] IN2_FUNC = DIF_FUNC_STOP,
  parameter logic [15:0] IN2_EDGE = DIF_EDGE_POSITIVE,
  parameter int RESET_FILTER_CYCLES = DIF_RESET_FILTER_CYCLES,
  parameter logic [31:0] ABORT_READ_ONLY = 32'h06010002,
  parameter logic [31:0] ABORT_NO_OBJECT = 32'h06020000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] din,
  input wire logic analog_mode,
  input wire logic op_enabled,
  input wire logic od_req,
  input wire logic od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  output logic od_ack,
  output logic od_abort,
  output logic [31:0] od_abort_code,
  output logic [15:0] od_rdata,
  output logic cmd_run,
  output logic cmd_stop,
  output logic cmd_standby,
  output logic cmd_hw_reset,
  output logic limit_stop
);

  // Refuse configurations the logic cannot serve
  if (IN1_FUNC > DIF_FUNC_COUNTER_CLOCKWISE_LIMIT ||
      IN2_FUNC > DIF_FUNC_COUNTER_CLOCKWISE_LIMIT) begin : g_bad_func
    $error("dif_inputs: function code out of range");
  end
  if (IN1_EDGE > DIF_EDGE_NEGATIVE || IN2_EDGE > DIF_EDGE_NEGATIVE) begin : g_bad_edge
    $error("dif_inputs: edge code out of range");
  end
  if (RESET_FILTER_CYCLES < 1) begin : g_bad_filter
    $error("dif_inputs: reset filter must be at least one cycle");
  end

  // Fixed manufacturer assignment per input
  logic [15:0] func_sel [2];
  logic [15:0] edge_sel [2];
  assign func_sel[0] = IN1_FUNC;
  assign func_sel[1] = IN2_FUNC;
  assign edge_sel[0] = IN1_EDGE;
  assign edge_sel[1] = IN2_EDGE;

  logic [1:0] din_q, din_d;
  logic [1:0] trig;
  logic [1:0] active;
  logic [31:0] filt_q [2];
  logic [31:0] filt_d [2];
  logic [1:0] filt_fire;

  // Input level history and edge detection
  always_comb begin
    din_d = din;
    for (int i = 0; i < 2; i++) begin
      if (edge_sel[i] == DIF_EDGE_NEGATIVE) begin
        trig[i] = din_q[i] & ~din[i];
        active[i] = ~din[i];
      end else begin
        trig[i] = ~din_q[i] & din[i];
        active[i] = din[i];
      end
      if (func_sel[i] == DIF_FUNC_NONE) begin
        trig[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      din_q <= 2'b00;
    end else begin
      din_q <= din_d;
    end
  end

  // Reset filter: armed by the edge, fires after the input stays active
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      filt_d[i] = filt_q[i];
      filt_fire[i] = 1'b0;
      if (func_sel[i] != DIF_FUNC_RESET || !active[i]) begin
        filt_d[i] = 32'h0000_0000;
      end else if (filt_q[i] == 32'h0000_0000) begin
        if (trig[i]) begin
          filt_d[i] = 32'h0000_0001;
        end
      end else if (filt_q[i] == 32'(RESET_FILTER_CYCLES)) begin
        filt_fire[i] = 1'b1;
        filt_d[i] = 32'(RESET_FILTER_CYCLES) + 32'h0000_0001;
      end else if (filt_q[i] < 32'(RESET_FILTER_CYCLES)) begin
        filt_d[i] = filt_q[i] + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q[0] <= 32'h0000_0000;
      filt_q[1] <= 32'h0000_0000;
    end else begin
      filt_q[0] <= filt_d[0];
      filt_q[1] <= filt_d[1];
    end
  end

  // Drive commands from the assigned functions
  logic run_d, stop_d, standby_d, hw_reset_d, limit_d;
  logic run_q, stop_q, standby_q, hw_reset_q, limit_q;

  always_comb begin
    run_d = 1'b0;
    stop_d = 1'b0;
    standby_d = 1'b0;
    hw_reset_d = |filt_fire;
    limit_d = 1'b0;
    for (int i = 0; i < 2; i++) begin
      unique case (func_sel[i])
        DIF_FUNC_RUN: begin
          if (trig[i] && analog_mode) run_d = 1'b1;
        end
        DIF_FUNC_STOP: begin
          if (trig[i] && analog_mode) stop_d = 1'b1;
        end
        DIF_FUNC_EMERGENCY: begin
          if (trig[i] && op_enabled) standby_d = 1'b1;
        end
        DIF_FUNC_CLOCKWISE_LIMIT, DIF_FUNC_COUNTER_CLOCKWISE_LIMIT: begin
          if (din[i]) limit_d = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      stop_q <= 1'b0;
      standby_q <= 1'b0;
      hw_reset_q <= 1'b0;
      limit_q <= 1'b0;
    end else begin
      run_q <= run_d;
      stop_q <= stop_d;
      standby_q <= standby_d;
      hw_reset_q <= hw_reset_d;
      limit_q <= limit_d;
    end
  end

  assign cmd_run = run_q;
  assign cmd_stop = stop_q;
  assign cmd_standby = standby_q;
  assign cmd_hw_reset = hw_reset_q;
  assign limit_stop = limit_q;

  // Object dictionary read port, answered one cycle after the request
  logic ack_d, abort_d;
  logic ack_q, abort_q;
  logic [31:0] code_d, code_q;
  logic [15:0] rdata_d, rdata_q;
  logic sel_ok;
  logic sel_idx;

  always_comb begin
    ack_d = od_req;
    abort_d = 1'b0;
    code_d = 32'h0000_0000;
    rdata_d = 16'h0000;
    sel_ok = 1'b1;
    sel_idx = (od_index == DIF_IDX_INPUT_TWO);
    if (od_req) begin
      if (od_index != DIF_IDX_INPUT_ONE && od_index != DIF_IDX_INPUT_TWO) begin
        sel_ok = 1'b0;
        code_d = ABORT_NO_OBJECT;
      end else begin
        unique case (od_subindex)
          DIF_SUB_ENTRY_COUNT: rdata_d = DIF_ENTRY_COUNT_RST;
          DIF_SUB_FUNC_SELECT: rdata_d = func_sel[sel_idx];
          DIF_SUB_LEVEL_STATE: begin
            rdata_d = din_q[sel_idx] ? DIF_STATE_HIGH : DIF_STATE_LOW;
          end
          DIF_SUB_EDGE_SELECT: rdata_d = edge_sel[sel_idx];
          default: begin
            sel_ok = 1'b0;
            code_d = DIF_ABORT_NO_SUBINDEX;
          end
        endcase
        if (sel_ok && od_write) begin
          sel_ok = 1'b0;
          rdata_d = 16'h0000;
          code_d = ABORT_READ_ONLY;
        end
      end
      abort_d = ~sel_ok;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      abort_q <= 1'b0;
      code_q <= 32'h0000_0000;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= ack_d;
      abort_q <= abort_d;
      code_q <= code_d;
      rdata_q <= rdata_d;
    end
  end

  assign od_ack = ack_q;
  assign od_abort = abort_q;
  assign od_abort_code = code_q;
  assign od_rdata = rdata_q;

endmodule : dif_inputs

// file: verification/dif_inputs_asserts.sv
`timescale 1ns/10ps
module dif_inputs_asserts
  import dif_pkg::*;
#(parameter logic [15:0] IN1_FUNC = DIF_FUNC_RUN,
  parameter logic [15:0] IN1_EDGE = DIF_EDGE_POSITIVE) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] din,
  input wire logic analog_mode,
  input wire logic op_enabled,
  input wire logic od_req,
  input wire logic od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic od_ack,
  input wire logic od_abort,
  input wire logic [31:0] od_abort_code,
  input wire logic [15:0] od_rdata,
  input wire logic cmd_run,
  input wire logic cmd_standby
);
  // Read of the first input object
  logic rd1;
  assign rd1 = od_req && !od_write && od_index == DIF_IDX_INPUT_ONE;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // State read with the pin held still
  sequence s_state_rd;
    rd1 && od_subindex == DIF_SUB_LEVEL_STATE ##0 $stable(din[0]);
  endsequence
  sequence s_pin_rise;
    $rose(din[0]) ##0 analog_mode && IN1_FUNC == DIF_FUNC_RUN &&
      IN1_EDGE == DIF_EDGE_POSITIVE;
  endsequence
  AST_ACK: assert property (od_ack == $past(od_req))
    else $error("answer timing wrong");
  AST_RO: assert property (od_req && od_write |=> od_abort)
    else $error("write not refused");
  AST_SUB: assert property (rd1 && od_subindex > 8'h03 |=>
    od_abort && od_abort_code == DIF_ABORT_NO_SUBINDEX)
    else $error("bad sub-index not refused");
  AST_CNT: assert property (rd1 && od_subindex == 8'h00 |=>
    od_rdata == DIF_ENTRY_COUNT_RST) else $error("entry count wrong");
  AST_FUNC: assert property (rd1 && od_subindex == 8'h01 |=>
    !od_abort && od_rdata == IN1_FUNC) else $error("function wrong");
  AST_STATE: assert property (s_state_rd |=>
    od_rdata == {15'h0000, $past(din[0])}) else $error("state wrong");
  AST_EDGE: assert property (rd1 && od_subindex == 8'h03 |=>
    od_rdata == IN1_EDGE) else $error("edge field wrong");
  AST_RUN: assert property (cmd_run |-> $past(analog_mode))
    else $error("run outside analog mode");
  AST_RISE: assert property (s_pin_rise |=> cmd_run)
    else $error("run edge missed");
  AST_STBY: assert property (cmd_standby |-> $past(op_enabled))
    else $error("standby without operation enabled");
endmodule : dif_inputs_asserts

bind dif_inputs dif_inputs_asserts #(.IN1_FUNC(IN1_FUNC),
  .IN1_EDGE(IN1_EDGE)) u_chk (.*);

// file: verification/dif_client.sv
`timescale 1ns/10ps
module dif_client (
  input wire logic mclk,
  input wire logic od_ack,
  input wire logic od_abort,
  input wire logic [31:0] od_abort_code,
  input wire logic [15:0] od_rdata,
  output logic od_req,
  output logic od_write,
  output logic [15:0] od_index,
  output logic [7:0] od_subindex
);
  initial begin
    od_req = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
  end
  // One access; qualifiers inverted a cycle after release
  task automatic access(input logic w, input logic [15:0] idx,
    input logic [7:0] sub, output logic [49:0] ans);
    @(posedge mclk);
    od_req <= 1'b1;
    od_write <= w;
    od_index <= idx;
    od_subindex <= sub;
    @(posedge mclk);
    od_req <= 1'b0;
    #1;
    ans = {od_ack, od_abort, od_abort_code, od_rdata};
    @(posedge mclk);
    od_write <= ~w;
    od_index <= ~idx;
    od_subindex <= ~sub;
  endtask : access
endmodule : dif_client

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import dif_pkg::*;
;
  localparam logic [15:0] F2 = DIF_FUNC_EMERGENCY;
  localparam int FILT = 8;
  logic cmd_run_b, cmd_stop_b, limit_c, hw_reset_c;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] din = 2'b00;
  logic am = 1'b0;
  logic oe = 1'b0;
  logic od_req, od_write, od_ack, od_abort, cmd_run, cmd_standby;
  logic [15:0] od_index, od_rdata, ri;
  logic [7:0] od_subindex;
  logic [31:0] od_abort_code;
  int err_total = 0;
  int total_checks = 0;
  always #12.5 mclk = ~mclk;
  // Input one keeps its run function while analog mode is driven
  dif_inputs #(.IN2_FUNC(F2), .RESET_FILTER_CYCLES(FILT)) uut (
    .analog_mode(am), .op_enabled(oe), .cmd_stop(), .cmd_hw_reset(),
    .limit_stop(), .*);
  // Stop on falling input one, run on input two; shares pins and bus
  dif_inputs #(.IN1_FUNC(DIF_FUNC_STOP), .IN1_EDGE(DIF_EDGE_NEGATIVE),
    .IN2_FUNC(DIF_FUNC_RUN)) uut_b (
    .mclk(mclk), .rst_n(rst_n), .din(din), .analog_mode(am),
    .op_enabled(oe), .od_req(od_req), .od_write(od_write),
    .od_index(od_index), .od_subindex(od_subindex), .od_ack(),
    .od_abort(), .od_abort_code(), .od_rdata(), .cmd_run(cmd_run_b),
    .cmd_stop(cmd_stop_b), .cmd_standby(), .cmd_hw_reset(),
    .limit_stop());
  // Limit and active-low reset; no run input, so kept out of analog mode
  dif_inputs #(.IN1_FUNC(DIF_FUNC_CLOCKWISE_LIMIT),
    .IN2_FUNC(DIF_FUNC_RESET), .IN2_EDGE(DIF_EDGE_NEGATIVE),
    .RESET_FILTER_CYCLES(FILT)) uut_c (
    .mclk(mclk), .rst_n(rst_n), .din(din), .analog_mode(1'b0),
    .op_enabled(oe), .od_req(od_req), .od_write(od_write),
    .od_index(od_index), .od_subindex(od_subindex), .od_ack(),
    .od_abort(), .od_abort_code(), .od_rdata(), .cmd_run(),
    .cmd_stop(), .cmd_standby(), .cmd_hw_reset(hw_reset_c),
    .limit_stop(limit_c));
  dif_client cli (.*);
  task automatic check(input logic [49:0] got, input logic [49:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Expected answer: abort flag, code, data
  function automatic logic [48:0] exp_od(logic w, logic [15:0] idx,
    logic [7:0] sub, logic [1:0] pins);
    logic one;
    one = idx == DIF_IDX_INPUT_ONE;
    if (!one && idx != DIF_IDX_INPUT_TWO) return {1'b1, 32'h06020000, 16'h0};
    if (sub > 8'h03) return {1'b1, DIF_ABORT_NO_SUBINDEX, 16'h0};
    if (w) return {1'b1, 32'h06010002, 16'h0};
    case (sub[1:0])
      2'h0: return {33'h0, DIF_ENTRY_COUNT_RST};
      2'h1: return {33'h0, one ? DIF_FUNC_RUN : F2};
      2'h2: return {33'h0, 15'h0, one ? pins[0] : pins[1]};
      default: return {33'h0, DIF_EDGE_POSITIVE};
    endcase
  endfunction : exp_od
  task automatic od(input logic w, input logic [15:0] idx,
    input logic [7:0] sub);
    logic [49:0] ans;
    cli.access(w, idx, sub, ans);
    check(ans, {1'b1, exp_od(w, idx, sub, din)});
  endtask : od
  // Rising pin with mode and state set, command sampled a cycle later
  task automatic pulse(input int b, input logic a, input logic e);
    @(posedge mclk);
    din[b] <= 1'b1;
    am <= a;
    oe <= e;
    @(posedge mclk);
    #1;
    check(50'(cmd_run), 50'(b == 0 && a));
    check(50'(cmd_standby), 50'(b == 1 && e));
    @(posedge mclk);
    din[b] <= 1'b0;
  endtask : pulse
  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Reset, table of entries, command pulses, then random accesses
  initial begin
    void'($urandom(32'ha040));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      od(1'b0, i < 8 ? DIF_IDX_INPUT_ONE : DIF_IDX_INPUT_TWO,
        8'(i % 8));
    end
    od(1'b1, DIF_IDX_INPUT_TWO, DIF_SUB_EDGE_SELECT);
    od(1'b0, 16'h3023, DIF_SUB_ENTRY_COUNT);
    for (int i = 0; i < 8; i++) begin
      pulse(i % 2, i[1], i[2]);
    end
    // Held pins: run on rise, limit level, then stop and reset on fall
    @(posedge mclk);
    din <= 2'b11;
    am <= 1'b1;
    @(posedge mclk);
    #1;
    check(50'(cmd_run_b), 50'(1));
    check(50'(cmd_stop_b), 50'(0));
    check(50'(limit_c), 50'(1));
    @(posedge mclk);
    din <= 2'b00;
    @(posedge mclk);
    #1;
    check(50'(cmd_stop_b), 50'(1));
    check(50'(limit_c), 50'(0));
    for (int k = 1; k <= FILT + 1; k++) begin
      @(posedge mclk);
      #1;
      check(50'(hw_reset_c), 50'(k == FILT));
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      din <= 2'($urandom);
      ri = $urandom % 2 ? DIF_IDX_INPUT_ONE : DIF_IDX_INPUT_TWO;
      od(1'($urandom), $urandom % 4 ? ri : 16'($urandom),
        8'($urandom % 8));
    end
    results();
  end
endmodule : tb_top
